// ### include/vrf_pkg.sv
package vrf_pkg;

  localparam int MAX_VL_BITS      = 512;
  localparam int NARROW_BITS      = 128;
  localparam int MID_BITS         = 256;
  localparam int NUM_VREGS        = 32;
  localparam int NUM_VREGS_LEGACY = 8;
  localparam int NUM_MASKS        = 8;
  localparam int MASK_BITS        = 64;
  localparam int LANES            = MAX_VL_BITS / 8;
  localparam int UPPER_SAVE_BITS  = MID_BITS - NARROW_BITS;
  localparam int RC_FIELD_LSB     = 13;
  localparam int FP_FLAG_BITS     = 6;
  localparam logic [6:0] NARROW_BYTES = 7'h10;
  localparam logic [6:0] MID_BYTES    = 7'h20;
  localparam logic [6:0] WIDE_BYTES   = 7'h40;

  typedef enum logic [1:0] {PFX_LEGACY, PFX_COMPACT, PFX_EXTENDED} prefix_t;
  typedef enum logic [1:0] {VL_128, VL_256, VL_512} vlen_t;
  typedef enum logic [1:0] {ESZ_8, ESZ_16, ESZ_32, ESZ_64} esize_t;

  typedef struct packed {
    logic                   en;
    prefix_t                pfx;
    vlen_t                  vl;
    logic [4:0]             idx;
    esize_t                 esz;
    logic [2:0]             kidx;
    logic                   zeroing;
    logic                   bcast;
    logic [MAX_VL_BITS-1:0] data;
  } vwrite_t;

  typedef struct packed {
    logic [4:0] idx;
    vlen_t      vl;
    logic       legacy;
  } vread_t;

endpackage : vrf_pkg

// ### logic/vector_register_file_masking.sv
module vector_register_file_masking
  import vrf_pkg::*;
#(
  parameter int MAX_VL   = MAX_VL_BITS,
  parameter int RC_LSB   = RC_FIELD_LSB
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       mode_64,
  input  wire vwrite_t                    wr,
  input  wire vread_t                     rd_a,
  input  wire vread_t                     rd_b,
  output logic [MAX_VL_BITS-1:0]          rd_a_data,
  output logic [MAX_VL_BITS-1:0]          rd_b_data,
  input  wire logic                       kwr_en,
  input  wire logic [2:0]                 kwr_idx,
  input  wire logic [MASK_BITS-1:0]       kwr_data,
  input  wire logic [2:0]                 krd_idx,
  output logic [MASK_BITS-1:0]            krd_data,
  input  wire logic [4:0]                 save_idx,
  output logic [UPPER_SAVE_BITS-1:0]      save_upper,
  input  wire logic                       restore_en,
  input  wire logic [4:0]                 restore_idx,
  input  wire logic [UPPER_SAVE_BITS-1:0] restore_upper,
  output logic [MASK_BITS-1:0]            mem_elem_en,
  input  wire logic [MASK_BITS-1:0]       elem_exc,
  input  wire logic [FP_FLAG_BITS-1:0]    exc_flags,
  output logic [FP_FLAG_BITS-1:0]         fp_flag_update,
  input  wire logic [31:0]                fp_control_status_reg,
  input  wire logic                       rc_override,
  input  wire logic [1:0]                 rc_mode,
  input  wire logic                       rc_reg_form,
  input  wire logic                       rc_scalar,
  input  wire logic                       rc_vl512,
  output logic [1:0]                      round_mode,
  input  wire logic [7:0]                 disp8,
  input  wire logic [2:0]                 disp_scale_log2,
  output logic [31:0]                     long_displacement
);

  initial begin
    if (MAX_VL != 512) begin
      $error("Only a 512-bit maximum vector length is served");
    end
    if (RC_LSB < 0 || RC_LSB > 30) begin
      $error("Rounding field must lie inside the control register");
    end
  end

  logic [MAX_VL_BITS-1:0] vreg_q [NUM_VREGS];
  logic [MASK_BITS-1:0]   kreg_q [NUM_MASKS];

  logic [MAX_VL_BITS-1:0] old_row;
  logic [MAX_VL_BITS-1:0] new_row;
  logic [MAX_VL_BITS-1:0] src_data;
  logic [MASK_BITS-1:0]   kmask;
  logic [MASK_BITS-1:0]   active_elems;
  logic [6:0]             vl_bytes;
  logic [6:0]             elem_count;
  logic                   predicated;
  logic [4:0]             widx;

  // Outside 64-bit mode only the first eight registers can be encoded
  function automatic logic [4:0] eff_idx(input logic [4:0] idx, input logic m64);
    eff_idx = m64 ? idx : {2'h0, idx[2:0]};
  endfunction : eff_idx

  function automatic logic [6:0] bytes_of(input vlen_t vl);
    unique case (vl)
      VL_128:  bytes_of = NARROW_BYTES;
      VL_256:  bytes_of = MID_BYTES;
      VL_512:  bytes_of = WIDE_BYTES;
      default: bytes_of = NARROW_BYTES;
    endcase
  endfunction : bytes_of

  function automatic logic [MAX_VL_BITS-1:0] bcast_of(input logic [MAX_VL_BITS-1:0] d,
                                                      input esize_t esz);
    unique case (esz)
      ESZ_8:  bcast_of = {64{d[7:0]}};
      ESZ_16: bcast_of = {32{d[15:0]}};
      ESZ_32: bcast_of = {16{d[31:0]}};
      ESZ_64: bcast_of = {8{d[63:0]}};
    endcase
  endfunction : bcast_of

  // One storage row per register; every narrower name is a slice of it
  function automatic logic [MAX_VL_BITS-1:0] view_of(input logic [MAX_VL_BITS-1:0] row,
                                                     input vread_t r);
    if (r.legacy || r.vl == VL_128) begin
      view_of = {{(MAX_VL_BITS-NARROW_BITS){1'b0}}, row[NARROW_BITS-1:0]};
    end else if (r.vl == VL_256) begin
      view_of = {{(MAX_VL_BITS-MID_BITS){1'b0}}, row[MID_BITS-1:0]};
    end else begin
      view_of = row;
    end
  endfunction : view_of

  assign widx       = eff_idx(wr.idx, mode_64);
  assign old_row    = vreg_q[widx];
  assign src_data   = wr.bcast ? bcast_of(wr.data, wr.esz) : wr.data;
  assign kmask      = kreg_q[wr.kidx];
  assign vl_bytes   = (wr.pfx == PFX_LEGACY) ? NARROW_BYTES : bytes_of(wr.vl);
  assign elem_count = vl_bytes >> wr.esz;
  // Register zero as a predicate selector means no masking at all
  assign predicated = (wr.pfx == PFX_EXTENDED) && (wr.kidx != 3'h0);

  for (genvar b = 0; b < LANES; b++) begin : g_lane
    logic [5:0] elem;
    logic       in_vl;
    logic       kbit;
    logic [7:0] nbyte;
    assign elem  = 6'(b) >> wr.esz;
    assign kbit  = kmask[elem];
    assign in_vl = 7'(b) < vl_bytes;
    always_comb begin
      nbyte = old_row[b*8 +: 8];
      unique case (wr.pfx)
        PFX_LEGACY: begin
          if (in_vl) begin
            nbyte = src_data[b*8 +: 8];
          end
        end
        PFX_COMPACT: begin
          nbyte = in_vl ? src_data[b*8 +: 8] : 8'h00;
        end
        PFX_EXTENDED: begin
          if (!in_vl) begin
            nbyte = 8'h00;
          end else if (!predicated || kbit) begin
            nbyte = src_data[b*8 +: 8];
          end else if (wr.zeroing) begin
            nbyte = 8'h00;
          end
        end
        default: nbyte = old_row[b*8 +: 8];
      endcase
    end
    assign new_row[b*8 +: 8] = nbyte;
  end

  for (genvar e = 0; e < MASK_BITS; e++) begin : g_elem
    assign active_elems[e] = (7'(e) < elem_count) && (!predicated || kmask[e]);
  end

  // A restore to the register being written this cycle loses to the write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_VREGS; i++) begin
        vreg_q[i] <= '0;
      end
    end else begin
      if (restore_en) begin
        vreg_q[eff_idx(restore_idx, mode_64)][MID_BITS-1:NARROW_BITS] <= restore_upper;
      end
      if (wr.en) begin
        vreg_q[widx] <= new_row;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        kreg_q[i] <= '0;
      end
    end else if (kwr_en) begin
      kreg_q[kwr_idx] <= kwr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
      krd_data  <= '0;
    end else begin
      rd_a_data <= view_of(vreg_q[eff_idx(rd_a.idx, mode_64)], rd_a);
      rd_b_data <= view_of(vreg_q[eff_idx(rd_b.idx, mode_64)], rd_b);
      krd_data  <= kreg_q[krd_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      save_upper <= '0;
    end else begin
      save_upper <= vreg_q[eff_idx(save_idx, mode_64)][MID_BITS-1:NARROW_BITS];
    end
  end

  // Memory side and status flags follow the instruction on the write port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_elem_en    <= '0;
      fp_flag_update <= '0;
    end else begin
      mem_elem_en <= active_elems;
      if (|(elem_exc & active_elems)) begin
        fp_flag_update <= exc_flags;
      end else begin
        fp_flag_update <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      round_mode <= 2'h0;
    end else if (rc_override && rc_reg_form && (rc_scalar || rc_vl512)) begin
      round_mode <= rc_mode;
    end else begin
      round_mode <= fp_control_status_reg[RC_LSB +: 2];
    end
  end

  // Scaling is by the operand size the decoder reports, not by the prefix
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      long_displacement <= 32'h0;
    end else begin
      long_displacement <= 32'({{24{disp8[7]}}, disp8} << disp_scale_log2);
    end
  end

endmodule : vector_register_file_masking

// ### test/vector_register_file_masking_tb_top.sv
module vector_register_file_masking_tb_top
  import vrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [511:0] P  = {16{32'h1357_9bdf}};
  localparam logic [511:0] Q  = {16{32'h2468_ace0}};
  localparam logic [127:0] R  = {4{32'hc3c3_5a5a}};
  localparam logic [63:0]  KM = 64'h8f01;
  logic                   clk = 1'b0, rst_n = 1'b0, kwe = 1'b0, rse = 1'b0, m64 = 1'b1;
  vwrite_t                cmd = '0, wr;
  vread_t                 rd = '0;
  logic [MAX_VL_BITS-1:0] rda, rdb, cur, ex;
  logic [MASK_BITS-1:0]   kwd = '0, eexc = '0, krd, mee;
  logic [127:0]           sup;
  logic [31:0]            fcr = '0, ld;
  logic [7:0]             d8 = '0;
  logic [5:0]             rc = '0, ffu;
  logic [4:0]             sidx = '0;
  logic [2:0]             kwi = '0, kri = '0, scl = '0;
  logic [1:0]             rm;
  int                     n_fail = 0, samples_checked = 0;
  always #50 clk = ~clk;
  vrf_dp_model vrf_dp_model_inst (.clk(clk), .rst_n(rst_n), .cmd(cmd), .wr(wr));
  vector_register_file_masking vector_register_file_masking_inst (.clk(clk), .rst_n(rst_n),
    .mode_64(m64), .wr(wr), .rd_a(rd), .rd_b(rd), .rd_a_data(rda), .rd_b_data(rdb),
    .kwr_en(kwe), .kwr_idx(kwi), .kwr_data(kwd), .krd_idx(kri), .krd_data(krd),
    .save_idx(sidx), .save_upper(sup), .restore_en(rse), .restore_idx(5'd17),
    .restore_upper(R), .mem_elem_en(mee), .elem_exc(eexc), .exc_flags(6'h3f),
    .fp_flag_update(ffu), .fp_control_status_reg(fcr), .rc_override(rc[0]),
    .rc_reg_form(rc[1]), .rc_scalar(rc[2]), .rc_vl512(rc[3]), .rc_mode(rc[5:4]),
    .round_mode(rm), .disp8(d8), .disp_scale_log2(scl), .long_displacement(ld));
  task automatic chk(input logic [511:0] got, input logic [511:0] e);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("[ERR] %0t value %h", $time, got);
    end
  endtask : chk
  task automatic wv(input prefix_t p, input vlen_t v, input logic [2:0] k, input logic z,
                    input logic [511:0] d, input logic b = 1'b0);
    @(posedge clk);
    cmd <= '{en:1'b1, pfx:p, vl:v, idx:5'd17, esz:ESZ_32, kidx:k, zeroing:z, bcast:b, data:d};
    @(posedge clk);
    cmd.en <= 1'b0;
    @(posedge clk);
  endtask : wv
  task automatic rv(input vlen_t v, input logic lg, input logic [511:0] e);
    rd <= '{idx:5'd17, vl:v, legacy:lg};
    @(posedge clk);
    @(negedge clk);
    chk(rda, e);
    chk(rdb, e);
  endtask : rv
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wv(PFX_EXTENDED, VL_512, 3'h0, 1'b0, P);
    rv(VL_512, 1'b0, P);
    wv(PFX_LEGACY, VL_128, 3'h0, 1'b0, Q);
    rv(VL_512, 1'b0, {P[511:128], Q[127:0]});
    rv(VL_128, 1'b1, {384'h0, Q[127:0]});
    sidx <= 5'd17;
    @(posedge clk);
    @(negedge clk);
    chk(512'(sup), 512'(P[255:128]));
    rse <= 1'b1;
    @(posedge clk);
    rse <= 1'b0;
    rv(VL_512, 1'b0, {P[511:256], R, Q[127:0]});
    wv(PFX_COMPACT, VL_256, 3'h0, 1'b0, Q);
    rv(VL_512, 1'b0, {256'h0, Q[255:0]});
    wv(PFX_COMPACT, VL_128, 3'h0, 1'b0, P);
    rv(VL_512, 1'b0, {384'h0, P[127:0]});
    for (int i = 0; i < 8; i += 2) begin
      kwe <= 1'b1;
      kwi <= 3'(i);
      kwd <= KM ^ 64'(i ^ 2);
      @(posedge clk);
    end
    kwe <= 1'b0;
    for (int i = 0; i < 8; i += 2) begin
      kri <= 3'(i);
      @(posedge clk);
      @(negedge clk);
      chk(512'(krd), 512'(KM ^ 64'(i ^ 2)));
    end
    // Element 2 is masked off, so its exception must stay silent
    eexc <= 64'h4;
    cur = {384'h0, P[127:0]};
    for (int z = 0; z < 2; z++) begin
      wv(PFX_EXTENDED, VL_512, 3'h2, z[0], Q);
      for (int e = 0; e < 16; e++) begin
        ex[e*32+:32] = KM[e] ? Q[e*32+:32] : (z == 1 ? 32'h0 : cur[e*32+:32]);
      end
      @(negedge clk);
      chk(512'(mee), 512'(KM[15:0]));
      chk(512'(ffu), 512'h0);
      rv(VL_512, 1'b0, ex);
      cur = ex;
    end
    eexc <= 64'h1;
    @(posedge clk);
    @(negedge clk);
    chk(512'(ffu), 512'h3f);
    wv(PFX_EXTENDED, VL_256, 3'h0, 1'b0, P);
    rv(VL_512, 1'b0, {256'h0, P[255:0]});
    wv(PFX_EXTENDED, VL_512, 3'h0, 1'b0, {480'h0, 32'hdead_beef}, 1'b1);
    rv(VL_512, 1'b0, {16{32'hdead_beef}});
    // Outside 64-bit mode index 17 folds onto register 1, which was never written
    m64 <= 1'b0;
    rv(VL_512, 1'b0, 512'h0);
    m64 <= 1'b1;
    rst_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    rst_n <= 1'b1;
    rv(VL_512, 1'b0, 512'h0);
    for (int i = 0; i < 64; i++) begin
      rc <= 6'(i);
      fcr <= 32'(i) << 13;
      d8 <= 8'(i * 37);
      scl <= 3'(i);
      @(posedge clk);
    end
    rc <= 6'h17;
    fcr <= 32'h4000;
    d8 <= 8'hfe;
    scl <= 3'h3;
    @(posedge clk);
    @(negedge clk);
    chk(512'(rm), 512'h1);
    chk(512'(ld), 512'hffff_fff0);
    wrap_up();
  end
endmodule : vector_register_file_masking_tb_top

// ### test/vrf_dp_model.sv
module vrf_dp_model
  import vrf_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  input  wire vwrite_t cmd,
  output vwrite_t      wr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle issue slots carry inverted data so a stale payload is never mistaken for a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr <= '0;
    end else begin
      wr <= cmd.en ? cmd : cmd ^ vwrite_t'($bits(vwrite_t)'({MAX_VL_BITS{1'b1}}));
    end
  end
endmodule : vrf_dp_model

// ### test/vrf_props.sv
module vrf_props
  import vrf_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire vwrite_t                 wr,
  input wire vread_t                  rd_a,
  input wire logic [MAX_VL_BITS-1:0]  rd_a_data,
  input wire logic [MASK_BITS-1:0]    mem_elem_en,
  input wire logic [MASK_BITS-1:0]    elem_exc,
  input wire logic [FP_FLAG_BITS-1:0] exc_flags,
  input wire logic [FP_FLAG_BITS-1:0] fp_flag_update,
  input wire logic [31:0]             fp_control_status_reg,
  input wire logic                    rc_override,
  input wire logic [1:0]              rc_mode,
  input wire logic                    rc_reg_form,
  input wire logic                    rc_scalar,
  input wire logic                    rc_vl512,
  input wire logic [1:0]              round_mode,
  input wire logic [7:0]              disp8,
  input wire logic [2:0]              disp_scale_log2,
  input wire logic [31:0]             long_displacement
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_round_sel: assert property ($past(rst_n) |-> round_mode ==
    ($past(rc_override && rc_reg_form && (rc_scalar || rc_vl512)) ?
     $past(rc_mode) : $past(fp_control_status_reg[RC_FIELD_LSB +: 2])))
    else $error("round mode mismatch");
  a_disp_scale: assert property ($past(rst_n) |->
    long_displacement == $past(32'($signed(disp8)) << disp_scale_log2)) else $error("disp");
  a_flag_quiet: assert property ($past(rst_n) && $past(elem_exc) == '0 |->
    fp_flag_update == '0) else $error("flags without exception");
  a_flag_pass: assert property ($past(rst_n) |-> fp_flag_update == '0 ||
    fp_flag_update == $past(exc_flags)) else $error("flag value");
  a_no_pred: assert property ($past(rst_n && wr.kidx == 3'h0 && wr.vl == VL_512 &&
    wr.esz == ESZ_32 && wr.pfx == PFX_EXTENDED) |-> mem_elem_en == 64'hffff)
    else $error("unmasked span");
  a_span_mid: assert property ($past(rst_n && wr.vl == VL_256 && wr.esz == ESZ_32 &&
    wr.pfx != PFX_LEGACY) |-> mem_elem_en[63:8] == '0) else $error("mid span");
  a_span_narrow: assert property ($past(rst_n && wr.vl == VL_128 && wr.esz == ESZ_32 &&
    wr.pfx != PFX_LEGACY) |-> mem_elem_en[63:4] == '0) else $error("narrow span");
  a_legacy_read: assert property ($past(rst_n && rd_a.legacy) |->
    rd_a_data[511:128] == '0) else $error("legacy read upper");
  a_mid_read: assert property ($past(rst_n && !rd_a.legacy && rd_a.vl == VL_256) |->
    rd_a_data[511:256] == '0) else $error("mid read upper");
endmodule : vrf_props
bind vector_register_file_masking vrf_props vrf_props_inst (.clk, .rst_n, .wr, .rd_a,
  .rd_a_data, .mem_elem_en, .elem_exc, .exc_flags, .fp_flag_update, .fp_control_status_reg,
  .rc_override, .rc_mode, .rc_reg_form, .rc_scalar, .rc_vl512, .round_mode, .disp8,
  .disp_scale_log2, .long_displacement);
